// >>> dv/pin_board.sv
// model of the board at port 1: pull-ups and external open-drain sources
// assumes the unit pulls a pin low only when enabled and driving 0
module pin_board #(
	parameter int CH_COUNT = 4
) (
	input wire logic [CH_COUNT-1:0] pin_out,
	input wire logic [CH_COUNT-1:0] pin_oe_n,
	input wire logic [CH_COUNT-1:0] ext_low,
	output logic [CH_COUNT-1:0]     pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// wired-and over a pull-up, so a released line reads high, never stale
	assign pin_in = ~((~pin_oe_n & ~pin_out) | ext_low);
endmodule : pin_board

// >>> dv/timer_compare_capture_unit_chk.sv
// checker of the compare/capture unit: bus answers, flag and pin causes
// assumes it sees only the unit's ports; bound to every instance at the foot
module tcc_chk #(
	parameter int CH_COUNT = 4
) (
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire tcc_pkg::axil_req_t  axi_req,
	input wire tcc_pkg::axil_rsp_t  axi_rsp,
	input wire logic [15:0]         timer_count,
	input wire logic                timer_overflow,
	input wire logic [CH_COUNT-1:0] pin_in,
	input wire logic [CH_COUNT-1:0] pin_out,
	input wire logic [CH_COUNT-1:0] pin_oe_n,
	input wire logic [CH_COUNT-1:0] ext_irq_flag
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// cycles since a cause of pin change (qa) and since a pin move (qp), saturating
	logic [15:0]         tc_q;
	logic                bv_q;
	logic [CH_COUNT-1:0] pi_q;
	logic [3:0]          qa_q;
	logic [3:0]          qa_d;
	logic [3:0]          qp_q;
	logic [3:0]          qp_d;
	always_comb begin
		qa_d = (qa_q == 4'hf) ? qa_q : qa_q + 4'h1;
		qp_d = (qp_q == 4'hf) ? qp_q : qp_q + 4'h1;
		if (timer_count != tc_q || (axi_rsp.bvalid && !bv_q) || timer_overflow) begin
			qa_d = 4'h0;
		end
		if (pin_in != pi_q) begin
			qp_d = 4'h0;
		end
	end
	always_ff @(posedge aclk) begin
		tc_q <= timer_count;
		bv_q <= axi_rsp.bvalid;
		pi_q <= pin_in;
		qa_q <= aresetn ? qa_d : 4'h0;
		qp_q <= aresetn ? qp_d : 4'h0;
	end

	property p_wr_lat;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |-> ##1 !axi_rsp.bvalid ##1 axi_rsp.bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late or early");
	property p_b_done;
		$fell(axi_rsp.bvalid) |-> $past(axi_req.bready) && axi_rsp.awready && axi_rsp.wready;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write answer dropped wrongly");
	property p_b_block;
		axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
	endproperty
	a_b_block: assert property (p_b_block) else $error("new write taken during answer");
	property p_rd_lat;
		axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer not next cycle");
	property p_r_done;
		$fell(axi_rsp.rvalid) |-> $past(axi_req.rready) && axi_rsp.arready;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read answer dropped wrongly");
	property p_r_err;
		axi_rsp.rvalid && axi_rsp.rresp == tcc_pkg::RESP_SLVERR |-> axi_rsp.rdata == 32'h0;
	endproperty
	a_r_err: assert property (p_r_err) else $error("refused read carries data");
	property p_rst;
		$rose(aresetn) |-> axi_rsp.awready && axi_rsp.arready && !axi_rsp.bvalid && (&pin_oe_n) && (&pin_out) && !(|ext_irq_flag);
	endproperty
	a_rst: assert property (p_rst) else $error("outputs wrong after reset");
	property p_flag_clr;
		|($past(ext_irq_flag) & ~ext_irq_flag) |-> $rose(axi_rsp.bvalid);
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag fell without a write");
	property p_pin_cause;
		$changed(pin_out) |-> qa_d < 4'h5; // qa_d, so a write answered at this very edge counts as the cause
	endproperty
	a_pin_cause: assert property (p_pin_cause) else $error("pin moved without match or write");
	property p_flag_cause;
		|(ext_irq_flag & ~$past(ext_irq_flag)) |-> qa_q < 4'h6 || qp_q < 4'h9;
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag set without a cause");

	c_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp == tcc_pkg::RESP_SLVERR);
	c_pin_fall: cover property (|($past(pin_out) & ~pin_out));
	c_flag: cover property (|(ext_irq_flag & ~$past(ext_irq_flag)));
endmodule : tcc_chk

bind timer_compare_capture_unit tcc_chk #(.CH_COUNT(CH_COUNT)) chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.axi_req(axi_req),
	.axi_rsp(axi_rsp),
	.timer_count(timer_count),
	.timer_overflow(timer_overflow),
	.pin_in(pin_in),
	.pin_out(pin_out),
	.pin_oe_n(pin_oe_n),
	.ext_irq_flag(ext_irq_flag)
);

// >>> dv/timer_compare_capture_unit_test.sv
// self-checking bench of the compare/capture unit with a port board model
// assumes a 10 MHz aclk; the bench drives timer count and overflow itself
module timer_compare_capture_unit_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic               aclk;
	logic               aresetn;
	tcc_pkg::axil_req_t req;
	tcc_pkg::axil_rsp_t rsp;
	logic [15:0]        tcount;
	logic               tovf;
	logic [3:0]         pin_in;
	logic [3:0]         pin_out;
	logic [3:0]         pin_oe_n;
	logic [3:0]         flags;
	logic [3:0]         ext_low;
	logic [31:0]        rd_v;
	logic [1:0]         resp;
	logic [15:0]        ccv;
	logic [15:0]        t1;
	logic [15:0]        t2;
	int                 err_count;
	int                 check_count;
	int                 cycles;
	int                 seed;

	timer_compare_capture_unit #(.CH_COUNT(4)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.timer_count(tcount), .timer_overflow(tovf), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_irq_flag(flags));
	pin_board #(.CH_COUNT(4)) board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_low(ext_low), .pin_in(pin_in));

	// bench clock, 100 ns period
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// a hang is cut short well above the expected run length
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	function automatic logic [7:0] cca(input int ch, input int hi);
		return tcc_pkg::OFF_CH_BASE + 8'(ch) * tcc_pkg::CH_STRIDE + ((hi != 0) ? tcc_pkg::OFF_HI : 8'h00);
	endfunction : cca

	function automatic logic [31:0] fn(input int ch, input tcc_pkg::chan_fn_t f);
		return 32'(f) << (2 * ch);
	endfunction : fn

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// write: address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				done = 1'b1;
				resp = rsp.bresp;
				req.bready <= 1'b0;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		rd_v = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), rd_v, e);
	endtask : rdc

	// a channel register is two bytes, low then high
	task automatic rcc(input int ch);
		rd(cca(ch, 0));
		ccv[7:0] = rd_v[7:0];
		rd(cca(ch, 1));
		ccv[15:8] = rd_v[7:0];
	endtask : rcc

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// one-cycle timer match, then back to a neutral count
	task automatic match(input logic [15:0] v);
		@(posedge aclk) tcount <= v;
		@(posedge aclk) tcount <= 16'h1234;
		cyc(3);
	endtask : match

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict

	initial begin
		seed = 96;
		req = '0;
		tcount = 16'h1234;
		tovf = 1'b0;
		ext_low = 4'h0;
		aresetn = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(tcc_pkg::OFF_CTRL, 32'h0);
		rdc(tcc_pkg::OFF_ENABLE, 32'h0);
		rdc(tcc_pkg::OFF_SHADOW, 32'hf);
		rdc(tcc_pkg::OFF_TIMER, 32'h1234);
		rdc(8'hfc, 32'h0);
		chk("rresp", resp, tcc_pkg::RESP_SLVERR);
		wr(8'hfc, 32'h1);
		chk("bresp", resp, tcc_pkg::RESP_SLVERR);
		// plain port use: latch zero pulls pin zero low, the pin falls and flags channel zero
		wr(tcc_pkg::OFF_PORT, 32'he);
		cyc(4);
		chk("oe_n port", pin_oe_n, 4'he);
		rdc(tcc_pkg::OFF_PORT, 32'he);
		chk("flag pin0", flags, 4'h1);
		wr(tcc_pkg::OFF_PORT, 32'hf);
		wr(tcc_pkg::OFF_FLAGS, 32'hf);
		$display("reset test done");
		// compare mode 1 on channel one
		wr(tcc_pkg::OFF_CTRL, 32'h1);
		wr(cca(1, 0), 32'h40);
		wr(cca(1, 1), 32'h0);
		wr(tcc_pkg::OFF_ENABLE, fn(1, tcc_pkg::FN_CMP));
		wr(tcc_pkg::OFF_PORT, 32'hd);
		cyc(5);
		chk("pin1 held", pin_out[1], 1'b1);
		chk("oe_n cmp", pin_oe_n, 4'hd);
		rdc(tcc_pkg::OFF_SHADOW, 32'hd);
		rdc(tcc_pkg::OFF_PORT, 32'hf);
		match(16'h40);
		chk("pin1 match", pin_out[1], 1'b0);
		rdc(tcc_pkg::OFF_FLAGS, 32'h2);
		chk("flag out", flags, 4'h2);
		@(posedge aclk) tcount <= 16'h40;
		wr(tcc_pkg::OFF_PORT, 32'hf);
		cyc(3);
		chk("pin1 open", pin_out[1], 1'b1);
		@(posedge aclk) tcount <= 16'h1234;
		// compare mode 0: overflow clears, match sets, writes ignored
		wr(tcc_pkg::OFF_CTRL, 32'h0);
		@(posedge aclk) tovf <= 1'b1;
		@(posedge aclk) tovf <= 1'b0;
		cyc(3);
		chk("pin1 ovf", pin_out[1], 1'b0);
		match(16'h40);
		chk("pin1 m0", pin_out[1], 1'b1);
		wr(tcc_pkg::OFF_PORT, 32'hd);
		cyc(3);
		chk("pin1 wr m0", pin_out[1], 1'b1);
		wr(tcc_pkg::OFF_FLAGS, 32'hf);
		$display("compare test done");
		// channel zero interrupt edges
		wr(cca(0, 0), 32'h50);
		wr(cca(0, 1), 32'h0);
		wr(tcc_pkg::OFF_CTRL, 32'h1);
		wr(tcc_pkg::OFF_ENABLE, fn(0, tcc_pkg::FN_CMP) | fn(1, tcc_pkg::FN_CMP));
		rdc(tcc_pkg::OFF_FLAGS, 32'h1);
		wr(tcc_pkg::OFF_FLAGS, 32'hf);
		@(posedge aclk) tcount <= 16'h50;
		cyc(2);
		rdc(tcc_pkg::OFF_FLAGS, 32'h0);
		@(posedge aclk) tcount <= 16'h1234;
		cyc(2);
		rdc(tcc_pkg::OFF_FLAGS, 32'h1);
		wr(tcc_pkg::OFF_FLAGS, 32'hf);
		wr(tcc_pkg::OFF_CTRL, 32'h3);
		@(posedge aclk) tcount <= 16'h50;
		cyc(2);
		rdc(tcc_pkg::OFF_FLAGS, 32'h1);
		@(posedge aclk) tcount <= 16'h1234;
		$display("edge test done");
		// capture: pin edges on channels zero and two, writes on three
		wr(tcc_pkg::OFF_CTRL, 32'h1);
		wr(tcc_pkg::OFF_SHADOW, 32'hf);
		wr(tcc_pkg::OFF_ENABLE, fn(0, tcc_pkg::FN_CAP0) | fn(2, tcc_pkg::FN_CAP0) | fn(3, tcc_pkg::FN_CAP1));
		cyc(6);
		wr(tcc_pkg::OFF_FLAGS, 32'hf);
		repeat (4) begin
			t1 = 16'($random(seed));
			t2 = 16'($random(seed));
			@(posedge aclk) begin
				tcount <= t1;
				ext_low <= 4'h5;
			end
			cyc(8);
			@(posedge aclk) begin
				tcount <= t2;
				ext_low <= 4'h0;
			end
			cyc(8);
			rcc(0);
			chk("cap ch0", ccv, t1);
			rcc(2);
			chk("cap ch2", ccv, t2);
			wr(cca(3, 0), 32'($random(seed)));
			rcc(3);
			chk("cap ch3", ccv, t2);
			rdc(tcc_pkg::OFF_FLAGS, 32'h5);
			wr(tcc_pkg::OFF_FLAGS, 32'hf);
		end
		$display("capture test done");
		give_verdict();
	end
endmodule : timer_compare_capture_unit_test

// >>> src/pin_sampler.sv
// three-stage sampler of one port pin with level and edge recognition
// assumes the pin is asynchronous to aclk; one aclk cycle is one machine cycle
module pin_sampler #(
	parameter logic RESET_LEVEL = 1'h1
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic [2:0] sync_q, sync_d;
	logic       level_q, level_d;
	logic       rise_q, rise_d;
	logic       fall_q, fall_d;

	// a change counts only once stages two and three agree; stage one feeds stage two alone
	always_comb begin
		sync_d  = {sync_q[1:0], pin_in};
		level_d = level_q;
		rise_d  = 1'b0;
		fall_d  = 1'b0;
		if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin
			level_d = sync_q[2];
			rise_d  = sync_q[2];
			fall_d  = ~sync_q[2];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_q  <= {3{RESET_LEVEL}};
			level_q <= RESET_LEVEL;
			rise_q  <= 1'b0;
			fall_q  <= 1'b0;
		end else begin
			sync_q  <= sync_d;
			level_q <= level_d;
			rise_q  <= rise_d;
			fall_q  <= fall_d;
		end
	end

	assign level = level_q;
	assign rise  = rise_q;
	assign fall  = fall_q;

endmodule : pin_sampler

// >>> src/tcc_pkg.sv
// shared constants, types and bus carriers of the timer compare/capture unit
// assumes an axi4-lite master with 8-bit byte addresses and 32-bit data
package tcc_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_ENABLE  = 8'h04;
	localparam logic [7:0] OFF_TIMER   = 8'h08;
	localparam logic [7:0] OFF_PORT    = 8'h0c;
	localparam logic [7:0] OFF_SHADOW  = 8'h10;
	localparam logic [7:0] OFF_FLAGS   = 8'h14;
	localparam logic [7:0] OFF_CH_BASE = 8'h20;
	localparam logic [7:0] CH_STRIDE   = 8'h08;
	localparam logic [7:0] OFF_HI      = 8'h04;

	// field positions of timer_control_reg
	localparam int CTRL_CMODE_BIT = 0;
	localparam int CTRL_EDGE_BIT  = 1;

	// reset values
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [15:0] ENABLE_RST = 16'h0000;
	localparam logic        LATCH_RST  = 1'h1;
	localparam logic [15:0] CC_RST     = 16'h0000;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// per-channel function, two bits each in compare_capture_enable_reg
	typedef enum logic [1:0] {
		FN_OFF  = 2'h0,
		FN_CAP0 = 2'h1,
		FN_CMP  = 2'h2,
		FN_CAP1 = 2'h3
	} chan_fn_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_RESP = 2'b10
	} rd_state_t;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;

endpackage : tcc_pkg

// >>> src/timer_compare_capture_unit.sv
// compare/capture channels beside a 16-bit timer, registers over axi4-lite
// assumes the timer count and overflow pulse come from logic on aclk, one clock per machine cycle
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
module timer_compare_capture_unit #(
	parameter int CH_COUNT = 4
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire tcc_pkg::axil_req_t axi_req,
	output tcc_pkg::axil_rsp_t      axi_rsp,
	input  wire logic [15:0]        timer_count,
	input  wire logic               timer_overflow,
	input  wire logic [CH_COUNT-1:0] pin_in,
	output logic [CH_COUNT-1:0]     pin_out,
	output logic [CH_COUNT-1:0]     pin_oe_n,
	output logic [CH_COUNT-1:0]     ext_irq_flag
);

	generate
		if (CH_COUNT < 1 || CH_COUNT > 8) begin : g_bad_count
			$error("CH_COUNT must lie between 1 and 8");
		end
	endgenerate

	// channel register address decode, shared by read and write paths
	function automatic logic is_chan(input logic [7:0] a, input int i, input logic hi);
		int base;
		base = int'(tcc_pkg::OFF_CH_BASE) + i * int'(tcc_pkg::CH_STRIDE) + (hi ? int'(tcc_pkg::OFF_HI) : 0);
		return a == 8'(base);
	endfunction : is_chan

	// bus state
	tcc_pkg::wr_state_t wst_q, wst_d;
	tcc_pkg::rd_state_t rst_q, rst_d;
	tcc_pkg::axil_rsp_t rsp_q, rsp_d;
	logic [7:0]         awaddr_q, awaddr_d;
	logic [31:0]        wdata_q, wdata_d;
	logic [3:0]         wstrb_q, wstrb_d;
	logic               aw_have_q, aw_have_d;
	logic               w_have_q, w_have_d;
	logic               wr_en;
	logic               wr_ok;
	logic [31:0]        rd_data;
	logic               rd_ok;

	// block state
	logic [7:0]          ctrl_q, ctrl_d;
	logic [15:0]         enable_q, enable_d;
	logic [CH_COUNT-1:0] shadow_q, shadow_d;
	logic [CH_COUNT-1:0] outlat_q, outlat_d;
	logic [CH_COUNT-1:0] pin_out_q, pin_out_d;
	logic [CH_COUNT-1:0] oe_n_q, oe_n_d;
	logic [CH_COUNT-1:0] flag_q, flag_d;
	logic [CH_COUNT-1:0] irq_prev_q, irq_prev_d;
	logic [CH_COUNT-1:0] cap_pend_q, cap_pend_d;
	logic [15:0]         cc_q [CH_COUNT];
	logic [15:0]         cc_d [CH_COUNT];

	logic [CH_COUNT-1:0] pin_level, pin_rise, pin_fall;
	logic [CH_COUNT-1:0] cmp_act, irq_in;
	logic                edge_sel, cmode1;

	assign edge_sel = ctrl_q[tcc_pkg::CTRL_EDGE_BIT];
	assign cmode1   = ctrl_q[tcc_pkg::CTRL_CMODE_BIT];

	// one sampler per port bit; capture and pin reads both see the agreed level
	genvar g;
	generate
		for (g = 0; g < CH_COUNT; g++) begin : g_pin
			pin_sampler #(
				.RESET_LEVEL (tcc_pkg::LATCH_RST)
			) u_sampler (
				.aclk    (aclk),
				.aresetn (aresetn),
				.pin_in  (pin_in[g]),
				.level   (pin_level[g]),
				.rise    (pin_rise[g]),
				.fall    (pin_fall[g])
			);
			// active for the whole time count equals the register
			assign cmp_act[g] = (tcc_pkg::chan_fn_t'(enable_q[2*g +: 2]) == tcc_pkg::FN_CMP)
				&& (timer_count == cc_q[g]);
			// compare use cuts the pin from the interrupt input
			assign irq_in[g]  = cmp_act[g] | ((tcc_pkg::chan_fn_t'(enable_q[2*g +: 2]) != tcc_pkg::FN_CMP)
				& pin_level[g]);
		end
	endgenerate

	// write channel: address and data taken in either order, response after both
	always_comb begin
		wst_d     = wst_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		wr_en     = 1'b0;
		rsp_d     = rsp_q;
		if (axi_req.awvalid && rsp_q.awready) begin
			awaddr_d  = axi_req.awaddr;
			aw_have_d = 1'b1;
		end
		if (axi_req.wvalid && rsp_q.wready) begin
			wdata_d  = axi_req.wdata;
			wstrb_d  = axi_req.wstrb;
			w_have_d = 1'b1;
		end
		unique case (wst_q)
			tcc_pkg::WR_IDLE: begin
				if (aw_have_q && w_have_q) begin
					wr_en       = wr_ok;
					rsp_d.bvalid = 1'b1;
					rsp_d.bresp  = wr_ok ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
					wst_d       = tcc_pkg::WR_RESP;
				end
			end
			tcc_pkg::WR_RESP: begin
				if (axi_req.bready) begin
					rsp_d.bvalid = 1'b0;
					aw_have_d    = 1'b0;
					w_have_d     = 1'b0;
					wst_d        = tcc_pkg::WR_IDLE;
				end
			end
		endcase
		rsp_d.awready = ~aw_have_d;
		rsp_d.wready  = ~w_have_d;
		// read channel: one read at a time, data registered
		rst_d = rst_q;
		unique case (rst_q)
			tcc_pkg::RD_IDLE: begin
				if (axi_req.arvalid && rsp_q.arready) begin
					rsp_d.rvalid = 1'b1;
					rsp_d.rdata  = rd_data;
					rsp_d.rresp  = rd_ok ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
					rst_d        = tcc_pkg::RD_RESP;
				end
			end
			tcc_pkg::RD_RESP: begin
				if (axi_req.rready) begin
					rsp_d.rvalid = 1'b0;
					rst_d        = tcc_pkg::RD_IDLE;
				end
			end
		endcase
		rsp_d.arready = (rst_d == tcc_pkg::RD_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_q     <= tcc_pkg::WR_IDLE;
			rst_q     <= tcc_pkg::RD_IDLE;
			rsp_q     <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
		end else begin
			wst_q     <= wst_d;
			rst_q     <= rst_d;
			rsp_q     <= rsp_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
		end
	end

	// address decode for both directions; unmapped offsets answer slverr
	always_comb begin
		wr_ok   = (awaddr_q == tcc_pkg::OFF_CTRL) || (awaddr_q == tcc_pkg::OFF_ENABLE)
			|| (awaddr_q == tcc_pkg::OFF_PORT) || (awaddr_q == tcc_pkg::OFF_SHADOW)
			|| (awaddr_q == tcc_pkg::OFF_FLAGS);
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		for (int i = 0; i < CH_COUNT; i++) begin
			if (is_chan(awaddr_q, i, 1'b0) || is_chan(awaddr_q, i, 1'b1)) begin
				wr_ok = 1'b1;
			end
		end
		if (axi_req.araddr == tcc_pkg::OFF_CTRL) begin
			rd_data[7:0] = ctrl_q;
		end else if (axi_req.araddr == tcc_pkg::OFF_ENABLE) begin
			rd_data[15:0] = enable_q;
		end else if (axi_req.araddr == tcc_pkg::OFF_TIMER) begin
			rd_data[15:0] = timer_count;
		end else if (axi_req.araddr == tcc_pkg::OFF_PORT) begin
			rd_data[CH_COUNT-1:0] = pin_level;
		end else if (axi_req.araddr == tcc_pkg::OFF_SHADOW) begin
			rd_data[CH_COUNT-1:0] = shadow_q;
		end else if (axi_req.araddr == tcc_pkg::OFF_FLAGS) begin
			rd_data[CH_COUNT-1:0] = flag_q;
		end else begin
			rd_ok = 1'b0;
		end
		for (int i = 0; i < CH_COUNT; i++) begin
			if (is_chan(axi_req.araddr, i, 1'b0)) begin
				rd_ok        = 1'b1;
				rd_data[7:0] = cc_q[i][7:0];
			end else if (is_chan(axi_req.araddr, i, 1'b1)) begin
				rd_ok        = 1'b1;
				rd_data[7:0] = cc_q[i][15:8];
			end
		end
	end

	// control, latches, flags and capture; registers hold one byte each in byte lane zero, except enable with two bytes in lanes zero and one
	always_comb begin
		logic              port_wr;
		tcc_pkg::chan_fn_t fn;
		logic              set;
		ctrl_d     = ctrl_q;
		enable_d   = enable_q;
		shadow_d   = shadow_q;
		outlat_d   = outlat_q;
		flag_d     = flag_q;
		irq_prev_d = irq_in;
		cap_pend_d = '0;
		pin_out_d  = pin_out_q;
		oe_n_d     = oe_n_q;
		port_wr    = wr_en && wstrb_q[0]
			&& (awaddr_q == tcc_pkg::OFF_PORT || awaddr_q == tcc_pkg::OFF_SHADOW);
		fn         = tcc_pkg::FN_OFF;
		set        = 1'b0;
		if (wr_en && wstrb_q[0] && awaddr_q == tcc_pkg::OFF_CTRL) begin
			ctrl_d = wdata_q[7:0];
		end
		if (wr_en && awaddr_q == tcc_pkg::OFF_ENABLE) begin
			if (wstrb_q[0]) enable_d[7:0] = wdata_q[7:0];
			if (wstrb_q[1]) enable_d[15:8] = wdata_q[15:8];
		end
		if (port_wr) begin
			shadow_d = wdata_q[CH_COUNT-1:0];
		end
		for (int i = 0; i < CH_COUNT; i++) begin
			fn    = tcc_pkg::chan_fn_t'(enable_q[2*i +: 2]);
			cc_d[i] = cc_q[i];
			// output latch per channel function
			if (fn == tcc_pkg::FN_CMP && cmode1) begin
				// transparent only while matching, so a write meanwhile reaches the pin
				if (cmp_act[i]) outlat_d[i] = shadow_d[i];
			end else if (fn == tcc_pkg::FN_CMP) begin
				if (cmp_act[i]) begin
					outlat_d[i] = 1'b1;
				end else if (timer_overflow) begin
					outlat_d[i] = 1'b0;
				end
			end else begin
				outlat_d[i] = shadow_d[i];
			end
			// compare drives both levels; otherwise the pin is pulled high unless latch is zero
			pin_out_d[i] = outlat_d[i];
			oe_n_d[i]    = (fn == tcc_pkg::FN_CMP) ? 1'b0 : shadow_d[i];
			// interrupt edge; channel zero alone has a selectable edge
			if (i == 0) begin
				set = edge_sel ? (irq_in[i] & ~irq_prev_q[i]) : (~irq_in[i] & irq_prev_q[i]);
			end else begin
				set = irq_in[i] & ~irq_prev_q[i];
			end
			// a clear in the same cycle as an event loses to the event
			if (wr_en && wstrb_q[0] && awaddr_q == tcc_pkg::OFF_FLAGS && wdata_q[i]) begin
				flag_d[i] = 1'b0;
			end
			if (set) begin
				flag_d[i] = 1'b1;
			end
			// capture triggers, taken one cycle after the event
			if (fn == tcc_pkg::FN_CAP0) begin
				if (i == 0) begin
					cap_pend_d[i] = edge_sel ? pin_rise[i] : pin_fall[i];
				end else begin
					cap_pend_d[i] = pin_rise[i];
				end
			end else if (fn == tcc_pkg::FN_CAP1) begin
				cap_pend_d[i] = wr_en && is_chan(awaddr_q, i, 1'b0);
			end
			if (wr_en && wstrb_q[0] && is_chan(awaddr_q, i, 1'b0)) begin
				cc_d[i][7:0] = wdata_q[7:0];
			end
			if (wr_en && wstrb_q[0] && is_chan(awaddr_q, i, 1'b1)) begin
				cc_d[i][15:8] = wdata_q[7:0];
			end
			if (cap_pend_q[i]) begin
				cc_d[i] = timer_count;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q     <= tcc_pkg::CTRL_RST;
			enable_q   <= tcc_pkg::ENABLE_RST;
			shadow_q   <= {CH_COUNT{tcc_pkg::LATCH_RST}};
			outlat_q   <= {CH_COUNT{tcc_pkg::LATCH_RST}};
			pin_out_q  <= {CH_COUNT{tcc_pkg::LATCH_RST}};
			oe_n_q     <= {CH_COUNT{tcc_pkg::LATCH_RST}};
			flag_q     <= '0;
			irq_prev_q <= {CH_COUNT{tcc_pkg::LATCH_RST}};
			cap_pend_q <= '0;
			for (int i = 0; i < CH_COUNT; i++) begin
				cc_q[i] <= tcc_pkg::CC_RST;
			end
		end else begin
			ctrl_q     <= ctrl_d;
			enable_q   <= enable_d;
			shadow_q   <= shadow_d;
			outlat_q   <= outlat_d;
			pin_out_q  <= pin_out_d;
			oe_n_q     <= oe_n_d;
			flag_q     <= flag_d;
			irq_prev_q <= irq_prev_d;
			cap_pend_q <= cap_pend_d;
			for (int i = 0; i < CH_COUNT; i++) begin
				cc_q[i] <= cc_d[i];
			end
		end
	end

	assign axi_rsp      = rsp_q;
	assign pin_out      = pin_out_q;
	assign pin_oe_n     = oe_n_q;
	assign ext_irq_flag = flag_q;

endmodule : timer_compare_capture_unit
